// ==== bench/midi_rx_asserts.sv ====
// Purpose: port checks on the message receiver
// Assumes: one clock, synchronous reset high
// Notes:   attached by bind at the foot
`timescale 1ns/1ns
`default_nettype none
module midi_rx_asserts #(parameter int NUM_PARTS = 16) (
	input wire logic                 CLK_IN, RST_IN, MSG_VALID_IN, MSG_READY_OUT, TX_VALID_OUT, TX_READY_IN,
	input wire logic [7:0]           MSG_STATUS_IN, TX_STATUS_OUT,
	input wire logic [6:0]           MSG_DATA1_IN, MSG_DATA2_IN, EV_NOTE_OUT, EV_VEL_OUT,
	input wire logic [NUM_PARTS-1:0] EV_ON_OUT, EV_OFF_OUT, EV_PROG_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	// message taken this cycle and its kind nibble
	wire logic       take = MSG_VALID_IN && MSG_READY_OUT;
	wire logic [3:0] kind = MSG_STATUS_IN[7:4];
	a_on_cause: assert property (|EV_ON_OUT |-> $past(take && kind == 4'h9 && MSG_DATA2_IN != 7'h00))
		else $error("note-on event without note-on");
	a_on_echo: assert property (|EV_ON_OUT |->
		EV_NOTE_OUT == $past(MSG_DATA1_IN) && EV_VEL_OUT == $past(MSG_DATA2_IN)) else $error("note-on fields wrong");
	a_off_novel: assert property (|EV_OFF_OUT |-> EV_VEL_OUT == 7'h00) else $error("off carries velocity");
	a_on_off_apart: assert property (!(|(EV_ON_OUT & EV_OFF_OUT))) else $error("on and off together");
	a_prog_cause: assert property (|EV_PROG_OUT |-> $past(take && kind == 4'hC)) else $error("stray program");
	a_tx_kinds: assert property (TX_VALID_OUT |-> TX_STATUS_OUT[7:5] == 3'b100) else $error("bad tx kind");
	a_tx_hold: assert property (TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_STATUS_OUT))
		else $error("tx dropped before ready");
	a_sweep_cause: assert property ($fell(MSG_READY_OUT) |-> $past(take && kind == 4'hB &&
		MSG_DATA1_IN[6:2] == 5'h10 && !MSG_DATA1_IN[0] && !MSG_DATA2_IN[6])) else $error("stall without pedal off");
endmodule
bind midi_rx midi_rx_asserts #(.NUM_PARTS(NUM_PARTS)) chk_i (.*);
`default_nettype wire

// ==== bench/midi_sender.sv ====
// Purpose: sequencer stand-in on the message port
// Assumes: valid and payload held until ready
// Notes:   released lines show inverted data
`timescale 1ns/1ns
`default_nettype none
module midi_sender (
	input  wire logic       clk_in,
	input  wire logic       ready_in,
	output var  logic       valid_out = 1'b0,
	output var  logic [7:0] status_out = 8'h00,
	output var  logic [6:0] data1_out = 7'h00,
	output var  logic [6:0] data2_out = 7'h00
);
	// one whole message; bank bytes before program change is the caller's duty
	task automatic send(input logic [7:0] s, input logic [6:0] a, input logic [6:0] b, output bit ok);
		int n = 0;
		@(posedge clk_in);
		status_out <= s; data1_out <= a; data2_out <= b; valid_out <= 1'b1;
		do begin @(posedge clk_in); n++; end while (!ready_in && n < 300);
		ok = ready_in;
		// stale data would hide a late sample, so invert it
		valid_out <= 1'b0; status_out <= ~s; data1_out <= ~a; data2_out <= ~b;
	endtask
endmodule
`default_nettype wire

// ==== bench/tb_midi_rx.sv ====
// Purpose: self-checking bench for the message receiver
// Assumes: default part windows, part p on channel p
// Notes:   rows first, then hand cases
`timescale 1ns/1ns
`default_nettype none
module tb_midi_rx;
	import midi_rx_pkg::*;
	logic CLK_IN = 0, RST_IN = 1, S_AXI_AWVALID_IN = 0, S_AXI_WVALID_IN = 0, S_AXI_BREADY_IN = 0, S_AXI_ARVALID_IN = 0;
	logic S_AXI_RREADY_IN = 0, KEY_VALID_IN = 0, KEY_DOWN_IN = 0, TX_READY_IN = 0;
	logic [11:0] S_AXI_AWADDR_IN = 0, S_AXI_ARADDR_IN = 0;
	logic [31:0] S_AXI_WDATA_IN = 0, rdat;
	logic [3:0] S_AXI_WSTRB_IN = 4'hF;
	logic [6:0] KEY_NOTE_IN = 7'h3C, KEY_VEL_IN = 7'h22;
	logic [1:0] rresp;
	wire logic MSG_VALID_IN, MSG_READY_OUT, S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT;
	wire logic S_AXI_RVALID_OUT, KEY_READY_OUT, TX_VALID_OUT;
	wire logic [1:0] S_AXI_BRESP_OUT, S_AXI_RRESP_OUT;
	wire logic [31:0] S_AXI_RDATA_OUT;
	wire logic [7:0] MSG_STATUS_IN, TX_STATUS_OUT;
	wire logic [6:0] MSG_DATA1_IN, MSG_DATA2_IN, EV_NOTE_OUT, EV_VEL_OUT, TX_DATA1_OUT, TX_DATA2_OUT;
	wire logic [15:0] EV_ON_OUT, EV_OFF_OUT, EV_PROG_OUT;
	int fail_count = 0, cmp_count = 0, n;
	bit ok;
	// rows: status, data1, data2, expected {on, off}
	logic [23:0] rows [6] = '{{8'h90, 7'h3C, 7'h64, 2'b10}, {8'h80, 7'h3C, 7'h10, 2'b01}, {8'h91, 7'h7F, 7'h7F, 2'b10},
		{8'h91, 7'h7F, 7'h00, 2'b01}, {8'h90, 7'h00, 7'h01, 2'b10}, {8'hB0, 7'h07, 7'h20, 2'b00}};
	midi_rx DUT (.*);
	midi_sender snd (.clk_in(CLK_IN), .ready_in(MSG_READY_OUT), .valid_out(MSG_VALID_IN),
		.status_out(MSG_STATUS_IN), .data1_out(MSG_DATA1_IN), .data2_out(MSG_DATA2_IN));
	initial forever #5 CLK_IN = ~CLK_IN;
	task wrap_up;
		$display("mismatches %0d, checks %0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input bit c);
		cmp_count++;
		if (!c) begin fail_count++; $display("unexpected %0t value mismatch", $time); end
	endtask
	task tmo(input bit c);
		if (!c) begin fail_count++; $display("unexpected %0t no answer", $time); wrap_up(); end
	endtask
	task msg(input logic [7:0] s, input logic [6:0] a, input logic [6:0] b);
		snd.send(s, a, b, ok); tmo(ok);
	endtask
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int k = 0;
		@(posedge CLK_IN);
		S_AXI_AWADDR_IN <= a; S_AXI_WDATA_IN <= d; S_AXI_AWVALID_IN <= 1; S_AXI_WVALID_IN <= 1; S_AXI_BREADY_IN <= 1;
		do begin
			@(posedge CLK_IN); k++;
			if (S_AXI_AWREADY_OUT) S_AXI_AWVALID_IN <= 0;
			if (S_AXI_WREADY_OUT) S_AXI_WVALID_IN <= 0;
		end while (!S_AXI_BVALID_OUT && k < 50);
		S_AXI_BREADY_IN <= 0; tmo(k < 50); chk(S_AXI_BRESP_OUT === RESP_OKAY);
	endtask
	task automatic rd(input logic [11:0] a);
		int k = 0;
		@(posedge CLK_IN);
		S_AXI_ARADDR_IN <= a; S_AXI_ARVALID_IN <= 1; S_AXI_RREADY_IN <= 1;
		do begin @(posedge CLK_IN); k++; if (S_AXI_ARREADY_OUT) S_AXI_ARVALID_IN <= 0; end while (!S_AXI_RVALID_OUT && k < 50);
		rdat = S_AXI_RDATA_OUT; rresp = S_AXI_RRESP_OUT; S_AXI_RREADY_IN <= 0; tmo(k < 50);
	endtask
	initial begin
		repeat (4) @(posedge CLK_IN);
		RST_IN <= 0;
		foreach (rows[i]) begin
			msg(rows[i][23:16], rows[i][15:9], rows[i][8:2]); @(negedge CLK_IN);
			chk(EV_ON_OUT === (rows[i][1] ? 16'h0001 << rows[i][19:16] : 16'h0000));
			chk(EV_OFF_OUT === (rows[i][0] ? 16'h0001 << rows[i][19:16] : 16'h0000));
			if (rows[i][1]) chk(EV_NOTE_OUT === rows[i][15:9] && EV_VEL_OUT === rows[i][8:2]);
		end
		rd(12'h100); chk(rdat === 32'h000FFF00 && rresp === RESP_OKAY);
		rd(12'h118); chk(rresp === RESP_SLVERR);
		msg(8'hC0, 7'h0A, 7'h00); @(negedge CLK_IN); chk(EV_PROG_OUT === 16'h0001);
		wr(12'h100, 32'h000FFE00); msg(8'h90, 7'h3C, 7'h40); @(negedge CLK_IN); chk(EV_ON_OUT === 16'h0);
		// drum key-on receive off: only normal mode sounds
		for (int m = 0; m < 4; m++) begin
			wr(12'h100, {26'h0001FFC, m[1:0], 4'h0}); msg(8'h90, 7'h30, 7'h40); @(negedge CLK_IN);
			chk(EV_ON_OUT === {15'h0, m == 0});
		end
		wr(12'h100, 32'h000FFF00);
		msg(8'h90, 7'h3C, 7'h40); msg(8'hB0, 7'h40, 7'h40); msg(8'h80, 7'h3C, 7'h00); @(negedge CLK_IN);
		chk(EV_OFF_OUT === 16'h0);
		msg(8'hB0, 7'h40, 7'h3F); n = 0;
		do begin @(negedge CLK_IN); n++; end while (!(EV_OFF_OUT[0] === 1'b1 && EV_NOTE_OUT === 7'h3C) && n < 140);
		chk(n < 140);
		// first key enters an idle link, second an idle one already drained by ready high
		for (int k = 0; k < 2; k++) begin
			@(posedge CLK_IN); KEY_VALID_IN <= 1; KEY_DOWN_IN <= k[0]; n = 0;
			do begin @(posedge CLK_IN); n++; end while (!KEY_READY_OUT && n < 20);
			KEY_VALID_IN <= 0; tmo(n < 20); @(negedge CLK_IN);
			chk(TX_VALID_OUT === 1'b1 && TX_STATUS_OUT === {3'b100, k[0], 4'h0}
				&& {TX_DATA1_OUT, TX_DATA2_OUT} === 14'h1E22);
			@(posedge CLK_IN); TX_READY_IN <= 1;
		end
		wrap_up();
	end
endmodule
`default_nettype wire

// ==== hw/midi_rx.sv ====
// Purpose: per-part channel-message receiver with AXI4-Lite configuration and readback
// Assumes: messages arrive whole, one per cycle, on MSG_* with valid/ready
// Notes:   sustain/sostenuto release scans 128 notes; input stalls meanwhile
//
// Decided for this implementation: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module midi_rx
	import midi_rx_pkg::*;
#(
	parameter int NUM_PARTS = 16
) (
	input  wire logic                        CLK_IN,
	input  wire logic                        RST_IN,
	input  wire logic [midi_rx_pkg::ADDR_W-1:0] S_AXI_AWADDR_IN,
	input  wire logic                        S_AXI_AWVALID_IN,
	output logic                             S_AXI_AWREADY_OUT,
	input  wire logic [31:0]                 S_AXI_WDATA_IN,
	input  wire logic [3:0]                  S_AXI_WSTRB_IN,
	input  wire logic                        S_AXI_WVALID_IN,
	output logic                             S_AXI_WREADY_OUT,
	output logic [1:0]                       S_AXI_BRESP_OUT,
	output logic                             S_AXI_BVALID_OUT,
	input  wire logic                        S_AXI_BREADY_IN,
	input  wire logic [midi_rx_pkg::ADDR_W-1:0] S_AXI_ARADDR_IN,
	input  wire logic                        S_AXI_ARVALID_IN,
	output logic                             S_AXI_ARREADY_OUT,
	output logic [31:0]                      S_AXI_RDATA_OUT,
	output logic [1:0]                       S_AXI_RRESP_OUT,
	output logic                             S_AXI_RVALID_OUT,
	input  wire logic                        S_AXI_RREADY_IN,
	input  wire logic                        MSG_VALID_IN,
	output logic                             MSG_READY_OUT,
	input  wire logic [7:0]                  MSG_STATUS_IN,
	input  wire logic [6:0]                  MSG_DATA1_IN,
	input  wire logic [6:0]                  MSG_DATA2_IN,
	output logic [NUM_PARTS-1:0]             EV_ON_OUT,
	output logic [NUM_PARTS-1:0]             EV_OFF_OUT,
	output logic [NUM_PARTS-1:0]             EV_PROG_OUT,
	output logic [6:0]                       EV_NOTE_OUT,
	output logic [6:0]                       EV_VEL_OUT,
	input  wire logic                        KEY_VALID_IN,
	output logic                             KEY_READY_OUT,
	input  wire logic                        KEY_DOWN_IN,
	input  wire logic [6:0]                  KEY_NOTE_IN,
	input  wire logic [6:0]                  KEY_VEL_IN,
	output logic                             TX_VALID_OUT,
	input  wire logic                        TX_READY_IN,
	output logic [7:0]                       TX_STATUS_OUT,
	output logic [6:0]                       TX_DATA1_OUT,
	output logic [6:0]                       TX_DATA2_OUT
);
	import midi_rx_pkg::*;

	typedef enum logic [1:0] {S_IDLE = 2'b01, S_SCAN = 2'b10} scan_state_t;

	// software-written configuration
	logic [31:0]  ctrl_q;
	logic [31:0]  cfg_q [NUM_PARTS];     // channel, mode, enables
	logic [31:0]  base_q [NUM_PARTS];    // stored resonance [6:0], release [14:8]
	// controller state, written by received messages only
	logic [6:0]   vol_q [NUM_PARTS];
	logic [6:0]   pan_q [NUM_PARTS];
	logic [6:0]   expr_q [NUM_PARTS];
	logic [6:0]   mod_q [NUM_PARTS];
	logic [6:0]   gtime_q [NUM_PARTS];
	logic [6:0]   reso_q [NUM_PARTS];
	logic [6:0]   rel_q [NUM_PARTS];
	logic [6:0]   bmsb_pend_q [NUM_PARTS];
	logic [6:0]   blsb_pend_q [NUM_PARTS];
	logic [6:0]   bmsb_q [NUM_PARTS];
	logic [6:0]   blsb_q [NUM_PARTS];
	logic [6:0]   prog_q [NUM_PARTS];
	logic [6:0]   de_msb_q [NUM_PARTS];
	logic [6:0]   de_lsb_q [NUM_PARTS];
	logic [NUM_PARTS-1:0] sus_q;         // sustain_switch
	logic [NUM_PARTS-1:0] glide_q;
	logic [NUM_PARTS-1:0] sost_on_q;
	logic [NUM_PARTS-1:0] soft_q;
	logic [127:0] sounding_q [NUM_PARTS];
	logic [127:0] pend_q [NUM_PARTS];    // note-offs deferred by a pedal
	logic [127:0] sost_q [NUM_PARTS];    // notes caught by sostenuto
	scan_state_t  state_q;
	logic [6:0]   scan_q;
	// bus slave state
	logic         aw_full_q;
	logic         w_full_q;
	logic [11:0]  awaddr_q;
	logic [31:0]  wdata_q;
	logic [3:0]   wstrb_q;
	logic         bvalid_q;
	logic [1:0]   bresp_q;
	logic         rvalid_q;
	logic [1:0]   rresp_q;
	logic [31:0]  rdata_q;
	logic         tx_valid_q;
	logic [7:0]   tx_status_q;
	logic [6:0]   tx_d1_q;
	logic [6:0]   tx_d2_q;

	// address decode shared by read and write paths: {hit, part, word}
	function automatic logic [9:0] part_dec(input logic [11:0] a);
		logic [11:0] rel;
		logic [6:0]  idx;
		rel = a - PART_BASE;
		idx = rel[PART_SHIFT+6:PART_SHIFT];
		part_dec = {(a >= PART_BASE) && (32'(idx) < NUM_PARTS) && (rel[4:2] <= W_DATA), idx[3:0], rel[4:2], 2'h0};
	endfunction

	// stored value plus (value - 64), clamped to 0..127
	function automatic logic [6:0] sat_off(input logic [6:0] base, input logic [6:0] v);
		logic [8:0] sum;
		sum = {2'h0, base} + {2'h0, v};
		if (sum < {2'h0, CENTER}) begin
			sat_off = 7'h00;
		end else if (sum - {2'h0, CENTER} > {2'h0, MAX7}) begin
			sat_off = MAX7;
		end else begin
			sat_off = 7'(sum - {2'h0, CENTER});
		end
	endfunction

	// byte-lane merge for partial writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
		for (int b = 0; b < 4; b++) begin
			merge[b*8 +: 8] = s[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
		end
	endfunction

	// message decode common to all parts
	logic       msg_take;
	logic [3:0] kind;
	logic       is_on;
	logic       is_off;
	logic       is_cc;
	logic       is_prog;
	logic       ext_bank;
	assign MSG_READY_OUT = (state_q == S_IDLE);
	assign msg_take      = MSG_VALID_IN && MSG_READY_OUT;
	assign kind          = MSG_STATUS_IN[7:4];
	assign is_on         = (kind == ST_NOTE_ON) && (MSG_DATA2_IN != 7'h00);
	assign is_off        = (kind == ST_NOTE_OFF) || ((kind == ST_NOTE_ON) && (MSG_DATA2_IN == 7'h00));
	assign is_cc         = (kind == ST_CC);
	assign is_prog       = (kind == ST_PROG);
	assign ext_bank      = ctrl_q[CT_EXT_BANK];

	// per-part qualification of the current message
	logic [NUM_PARTS-1:0] hit;
	logic [NUM_PARTS-1:0] drum;
	logic [NUM_PARTS-1:0] take_on;
	logic [NUM_PARTS-1:0] take_off;
	logic [NUM_PARTS-1:0] take_cc;
	logic [NUM_PARTS-1:0] held;
	logic [NUM_PARTS-1:0] release_start;
	logic [NUM_PARTS-1:0] scan_rel;
	genvar gp;
	generate
		for (gp = 0; gp < NUM_PARTS; gp++) begin : g_part
			assign hit[gp]      = msg_take && (cfg_q[gp][CF_CHAN +: 4] == MSG_STATUS_IN[3:0]);
			assign drum[gp]     = (part_mode_t'(cfg_q[gp][CF_MODE +: 2]) != MODE_NORMAL);
			assign take_on[gp]  = hit[gp] && is_on && cfg_q[gp][EN_NOTE]
					&& (!drum[gp] || cfg_q[gp][EN_DON]);
			assign take_off[gp] = hit[gp] && is_off && cfg_q[gp][EN_NOTE]
					&& (!drum[gp] || cfg_q[gp][EN_DOFF]);
			assign take_cc[gp]  = hit[gp] && is_cc && cfg_q[gp][EN_CC];
			assign held[gp]     = sus_q[gp] || sost_q[gp][MSG_DATA1_IN];
			// a pedal letting go starts a sweep of deferred note-offs
			assign release_start[gp] = take_cc[gp] && (MSG_DATA2_IN < CENTER)
					&& (((MSG_DATA1_IN == CC_SUSTAIN) && cfg_q[gp][EN_SUS] && sus_q[gp])
					|| ((MSG_DATA1_IN == CC_SOST) && cfg_q[gp][EN_SOST] && sost_on_q[gp]));
			assign scan_rel[gp] = (state_q == S_SCAN) && pend_q[gp][scan_q]
					&& !sus_q[gp] && !sost_q[gp][scan_q];
		end
	endgenerate

	// release sweep sequencer: walks every note once per pedal release
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			state_q <= S_IDLE;
			scan_q  <= 7'h00;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					scan_q <= 7'h00;
					if (|release_start) begin
						state_q <= S_SCAN;
					end
				end
				S_SCAN: begin
					scan_q <= scan_q + 7'h01;
					if (scan_q == MAX7) begin
						state_q <= S_IDLE;
					end
				end
			endcase
		end
	end

	// note bookkeeping and note events
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			EV_ON_OUT   <= '0;
			EV_OFF_OUT  <= '0;
			EV_NOTE_OUT <= 7'h00;
			EV_VEL_OUT  <= 7'h00;
			for (int p = 0; p < NUM_PARTS; p++) begin
				sounding_q[p] <= '0;
				pend_q[p]     <= '0;
				sost_q[p]     <= '0;
			end
		end else begin
			EV_ON_OUT  <= take_on;
			EV_OFF_OUT <= (state_q == S_SCAN) ? scan_rel : (take_off & ~held);
			if (state_q == S_SCAN) begin
				EV_NOTE_OUT <= scan_q;
				EV_VEL_OUT  <= 7'h00;
			end else if (msg_take) begin
				EV_NOTE_OUT <= MSG_DATA1_IN;
				EV_VEL_OUT  <= is_on ? MSG_DATA2_IN : 7'h00;
			end
			for (int p = 0; p < NUM_PARTS; p++) begin
				if (scan_rel[p]) begin
					pend_q[p][scan_q]     <= 1'b0;
					sounding_q[p][scan_q] <= 1'b0;
				end
				if (take_on[p]) begin
					sounding_q[p][MSG_DATA1_IN] <= 1'b1;
					pend_q[p][MSG_DATA1_IN]     <= 1'b0;
				end else if (take_off[p] && held[p]) begin
					pend_q[p][MSG_DATA1_IN] <= 1'b1;
				end else if (take_off[p]) begin
					sounding_q[p][MSG_DATA1_IN] <= 1'b0;
				end
				// sostenuto press captures only what sounds right now
				if (take_cc[p] && (MSG_DATA1_IN == CC_SOST) && cfg_q[p][EN_SOST]) begin
					sost_q[p] <= (MSG_DATA2_IN >= CENTER) ? sounding_q[p] : '0;
				end
			end
		end
	end

	// controller and program state
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			EV_PROG_OUT <= '0;
			sus_q       <= '0;
			glide_q     <= '0;
			sost_on_q   <= '0;
			soft_q      <= '0;
			for (int p = 0; p < NUM_PARTS; p++) begin
				vol_q[p]       <= VOL_RESET;
				pan_q[p]       <= CENTER;
				expr_q[p]      <= MAX7;
				mod_q[p]       <= 7'h00;
				gtime_q[p]     <= 7'h00;
				reso_q[p]      <= CENTER;
				rel_q[p]       <= CENTER;
				bmsb_pend_q[p] <= 7'h00;
				blsb_pend_q[p] <= 7'h00;
				bmsb_q[p]      <= 7'h00;
				blsb_q[p]      <= 7'h00;
				prog_q[p]      <= 7'h00;
				de_msb_q[p]    <= 7'h00;
				de_lsb_q[p]    <= 7'h00;
			end
		end else begin
			EV_PROG_OUT <= hit & {NUM_PARTS{is_prog}};
			for (int p = 0; p < NUM_PARTS; p++) begin
				if (hit[p] && is_prog) begin
					prog_q[p] <= MSG_DATA1_IN;
					bmsb_q[p] <= bmsb_pend_q[p];
					blsb_q[p] <= ext_bank ? blsb_pend_q[p] : 7'h00;
				end
				if (take_cc[p]) begin
					unique case (MSG_DATA1_IN)
						CC_BANK_MSB: bmsb_pend_q[p] <= MSG_DATA2_IN;
						CC_BANK_LSB: blsb_pend_q[p] <= MSG_DATA2_IN;
						CC_MOD: begin
							if (cfg_q[p][EN_MOD]) begin
								mod_q[p] <= MSG_DATA2_IN;
							end
						end
						CC_GLIDE_TIME: begin
							if (!drum[p]) begin
								gtime_q[p] <= MSG_DATA2_IN;
							end
						end
						CC_DE_MSB: de_msb_q[p] <= MSG_DATA2_IN;
						CC_DE_LSB: de_lsb_q[p] <= MSG_DATA2_IN;
						CC_VOL: begin
							if (cfg_q[p][EN_VOL]) begin
								vol_q[p] <= MSG_DATA2_IN;
							end
						end
						CC_PAN: begin
							if (cfg_q[p][EN_PAN]) begin
								pan_q[p] <= MSG_DATA2_IN;
							end
						end
						CC_EXPR: begin
							if (cfg_q[p][EN_EXPR]) begin
								expr_q[p] <= MSG_DATA2_IN;
							end
						end
						CC_SUSTAIN: begin
							if (cfg_q[p][EN_SUS]) begin
								sus_q[p] <= (MSG_DATA2_IN >= CENTER);
							end
						end
						CC_GLIDE: begin
							if (cfg_q[p][EN_GLD] && !drum[p]) begin
								glide_q[p] <= (MSG_DATA2_IN >= CENTER);
							end
						end
						CC_SOST: begin
							if (cfg_q[p][EN_SOST]) begin
								sost_on_q[p] <= (MSG_DATA2_IN >= CENTER);
							end
						end
						CC_SOFT: begin
							if (cfg_q[p][EN_SOFT] && !drum[p]) begin
								soft_q[p] <= (MSG_DATA2_IN >= CENTER);
							end
						end
						CC_RESO: reso_q[p] <= MSG_DATA2_IN;
						CC_REL:  rel_q[p]  <= MSG_DATA2_IN;
						default: ;                                               // other controllers not handled
					endcase
				end
			end
		end
	end

	// outgoing link: only key-down/key-up become messages
	assign KEY_READY_OUT = !tx_valid_q || TX_READY_IN;
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			tx_valid_q  <= 1'b0;
			tx_status_q <= 8'h00;
			tx_d1_q     <= 7'h00;
			tx_d2_q     <= 7'h00;
		end else if (KEY_READY_OUT) begin
			tx_valid_q  <= KEY_VALID_IN;
			if (KEY_VALID_IN) begin
				tx_status_q <= {(KEY_DOWN_IN ? ST_NOTE_ON : ST_NOTE_OFF), ctrl_q[CT_TX_CHAN +: 4]};
				tx_d1_q     <= KEY_NOTE_IN;
				tx_d2_q     <= KEY_VEL_IN;
			end
		end
	end
	assign TX_VALID_OUT  = tx_valid_q;
	assign TX_STATUS_OUT = tx_status_q;
	assign TX_DATA1_OUT  = tx_d1_q;
	assign TX_DATA2_OUT  = tx_d2_q;

	// write channel capture: address and data accepted in either order
	logic       wr_fire;
	logic [9:0] wdec;
	assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
	assign wdec    = part_dec(awaddr_q);
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			awaddr_q  <= 12'h000;
			wdata_q   <= 32'h00000000;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID_IN && !aw_full_q) begin
				aw_full_q <= 1'b1;
				awaddr_q  <= S_AXI_AWADDR_IN;
			end
			if (S_AXI_WVALID_IN && !w_full_q) begin
				w_full_q <= 1'b1;
				wdata_q  <= S_AXI_WDATA_IN;
				wstrb_q  <= S_AXI_WSTRB_IN;
			end
			if (wr_fire) begin
				aw_full_q <= 1'b0;
				w_full_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= (wdec[9] || awaddr_q == CTRL_OFS || awaddr_q == STAT_OFS) ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && S_AXI_BREADY_IN) begin
				bvalid_q <= 1'b0;
			end
		end
	end
	assign S_AXI_AWREADY_OUT = !aw_full_q;
	assign S_AXI_WREADY_OUT  = !w_full_q;
	assign S_AXI_BVALID_OUT  = bvalid_q;
	assign S_AXI_BRESP_OUT   = bresp_q;

	// register file writes; read-only words ignore writes
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			ctrl_q <= CTRL_RESET;
			for (int p = 0; p < NUM_PARTS; p++) begin
				cfg_q[p]  <= CFG_RESET | 32'(p % 16);   // part n listens on channel n
				base_q[p] <= BASE_RESET;
			end
		end else if (wr_fire) begin
			if (awaddr_q == CTRL_OFS) begin
				ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
			end else if (wdec[9] && wdec[4:2] == W_CFG) begin
				cfg_q[wdec[8:5]] <= merge(cfg_q[wdec[8:5]], wdata_q, wstrb_q);
			end else if (wdec[9] && wdec[4:2] == W_BASE) begin
				base_q[wdec[8:5]] <= merge(base_q[wdec[8:5]], wdata_q, wstrb_q);
			end
		end
	end

	// read mux: live part state, effective offsets, decoded bank
	logic [9:0]  rdec;
	logic [3:0]  rp;
	logic [31:0] rmux;
	logic [1:0]  vtype;
	assign rdec = part_dec(S_AXI_ARADDR_IN);
	assign rp   = rdec[8:5];
	always_comb begin
		vtype = VT_NORMAL;
		if (ext_bank) begin
			unique case (bmsb_q[rp])
				MSB_SFX_VOICE: vtype = VT_SFX_VOICE;
				MSB_SFX_KIT:   vtype = VT_SFX_KIT;
				MSB_DRUM_KIT:  vtype = VT_DRUM_KIT;
				default:       vtype = VT_NORMAL;
			endcase
		end
		rmux = 32'h00000000;
		if (S_AXI_ARADDR_IN == CTRL_OFS) begin
			rmux = ctrl_q;
		end else if (S_AXI_ARADDR_IN == STAT_OFS) begin
			rmux = {24'h000000, scan_q, (state_q == S_SCAN)};
		end else if (rdec[9]) begin
			unique case (rdec[4:2])
				W_CFG:  rmux = cfg_q[rp];
				W_BASE: rmux = base_q[rp];
				W_LVL:  rmux = {1'b0, mod_q[rp], 1'b0, expr_q[rp], 1'b0, pan_q[rp], 1'b0, vol_q[rp]};
				W_CTL:  rmux = {1'b0, sat_off(base_q[rp][14:8], rel_q[rp]),
						1'b0, sat_off(base_q[rp][6:0], reso_q[rp]),
						cfg_q[rp][MW_AMP] && !drum[rp],
						cfg_q[rp][MW_FILT] && !drum[rp],
						glide_q[rp] && cfg_q[rp][CF_MONO],
						drum[rp], soft_q[rp], sost_on_q[rp], glide_q[rp], sus_q[rp],
						1'b0, gtime_q[rp]};
				W_BANK: rmux = {6'h00, vtype, 1'b0, prog_q[rp], 1'b0, blsb_q[rp], 1'b0, bmsb_q[rp]};
				default: rmux = {18'h00000, de_msb_q[rp], de_lsb_q[rp]};
			endcase
		end
	end

	// read channel: answer one cycle after the address is taken
	always_ff @(posedge CLK_IN) begin
		if (RST_IN) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= RESP_OKAY;
		end else if (S_AXI_ARVALID_IN && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rmux;
			rresp_q  <= (rdec[9] || S_AXI_ARADDR_IN == CTRL_OFS || S_AXI_ARADDR_IN == STAT_OFS) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && S_AXI_RREADY_IN) begin
			rvalid_q <= 1'b0;
		end
	end
	assign S_AXI_ARREADY_OUT = !rvalid_q;
	assign S_AXI_RVALID_OUT  = rvalid_q;
	assign S_AXI_RDATA_OUT   = rdata_q;
	assign S_AXI_RRESP_OUT   = rresp_q;
endmodule
`default_nettype wire

// ==== hw/midi_rx_pkg.sv ====
// Purpose: constants, field layout and enumerations for the channel-message receiver
// Assumes: 32-bit register words, 12-bit byte addresses, 7-bit message data bytes
// Notes:   offsets, cfg and ctrl field positions and reset constants of the receiver live here
// Overview of operation
// - transmit link carries only note-on and note-off
// - note-on with velocity zero acts as note-off
// - all note numbers accepted; velocity from note-on only
// - note receive disable drops part's note messages
// - drum part drops key-off when drum-off disabled
// - drum part drops key-on when drum-on disabled
// - drum part means drum or numbered drum-set mode
// - control-change receive disable drops all controllers
// - extended mode: upper byte voice type, lower bank
// - compatibility mode ignores lower bank byte
// - bank bytes held until next program change
// - modulation depth, gated; drums skip filter, amplitude
// - glide time stored; drum parts discard it
// - data entry upper and lower bytes stored
// - volume stored unless volume receive disabled
// - pan stored unless pan receive disabled
// - expression stored unless expression receive disabled
// - pedal values below 64 off, else on
// - sustain holds sounding notes past note-off
// - glide switch, legato in mono, drums ignore
// - sostenuto holds only notes sounding at press
// - resonance and release get value minus 64 offset
package midi_rx_pkg;
	localparam int          ADDR_W        = 12;
	localparam logic [11:0] CTRL_OFS      = 12'h000;  // global control
	localparam logic [11:0] STAT_OFS      = 12'h004;  // global status
	localparam logic [11:0] PART_BASE     = 12'h100;  // first part window
	localparam int          PART_SHIFT    = 5;        // 8 words per part
	localparam logic [2:0]  W_CFG         = 3'h0;     // per-part words
	localparam logic [2:0]  W_BASE        = 3'h1;
	localparam logic [2:0]  W_LVL         = 3'h2;
	localparam logic [2:0]  W_CTL         = 3'h3;
	localparam logic [2:0]  W_BANK        = 3'h4;
	localparam logic [2:0]  W_DATA        = 3'h5;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	localparam logic [3:0]  ST_NOTE_OFF   = 4'h8;     // status upper nibbles
	localparam logic [3:0]  ST_NOTE_ON    = 4'h9;
	localparam logic [3:0]  ST_CC         = 4'hB;
	localparam logic [3:0]  ST_PROG       = 4'hC;
	localparam logic [6:0]  CC_BANK_MSB   = 7'h00;    // controller numbers
	localparam logic [6:0]  CC_MOD        = 7'h01;
	localparam logic [6:0]  CC_GLIDE_TIME = 7'h05;
	localparam logic [6:0]  CC_DE_MSB     = 7'h06;
	localparam logic [6:0]  CC_VOL        = 7'h07;
	localparam logic [6:0]  CC_PAN        = 7'h0A;
	localparam logic [6:0]  CC_EXPR       = 7'h0B;
	localparam logic [6:0]  CC_BANK_LSB   = 7'h20;
	localparam logic [6:0]  CC_DE_LSB     = 7'h26;
	localparam logic [6:0]  CC_SUSTAIN    = 7'h40;
	localparam logic [6:0]  CC_GLIDE      = 7'h41;
	localparam logic [6:0]  CC_SOST       = 7'h42;
	localparam logic [6:0]  CC_SOFT       = 7'h43;
	localparam logic [6:0]  CC_RESO       = 7'h47;
	localparam logic [6:0]  CC_REL        = 7'h48;
	localparam logic [6:0]  CENTER        = 7'h40;    // pan centre, offset zero, pedal threshold
	localparam logic [6:0]  MAX7          = 7'h7F;
	localparam logic [6:0]  MSB_SFX_VOICE = 7'h40;    // voice type codes in upper bank byte
	localparam logic [6:0]  MSB_SFX_KIT   = 7'h7E;
	localparam logic [6:0]  MSB_DRUM_KIT  = 7'h7F;
	typedef enum logic [1:0] {VT_NORMAL = 2'h0, VT_SFX_VOICE = 2'h1, VT_SFX_KIT = 2'h2, VT_DRUM_KIT = 2'h3} voice_type_t;
	typedef enum logic [1:0] {MODE_NORMAL = 2'h0, MODE_DRUM = 2'h1, MODE_SET1 = 2'h2, MODE_SET2 = 2'h3} part_mode_t;
	localparam int CF_CHAN = 0;      // [3:0] receive channel
	localparam int CF_MODE = 4;      // [5:4] part mode
	localparam int CF_MONO = 6;      // voice_allocation_kind: 1 = mono
	localparam int EN_NOTE = 8;      // receive enables
	localparam int EN_CC   = 9;
	localparam int EN_MOD  = 10;
	localparam int EN_VOL  = 11;
	localparam int EN_PAN  = 12;
	localparam int EN_EXPR = 13;
	localparam int EN_SUS  = 14;     // part_sustain_rx_enable
	localparam int EN_GLD  = 15;
	localparam int EN_SOST = 16;
	localparam int EN_SOFT = 17;
	localparam int EN_DOFF = 18;     // drum note-off enable
	localparam int EN_DON  = 19;     // drum note-on enable
	localparam int MW_FILT = 20;     // modulation to filter
	localparam int MW_AMP  = 21;     // modulation to amplitude
	localparam logic [31:0] CFG_RESET  = 32'h000FFF00;
	localparam logic [31:0] BASE_RESET = 32'h00004040;
	localparam logic [6:0]  VOL_RESET  = 7'h64;
	localparam int CT_EXT_BANK = 0;  // 1 = extended bank mode
	localparam int CT_TX_CHAN  = 4;  // [7:4] transmit channel
	localparam logic [31:0] CTRL_RESET = 32'h00000001;
endpackage
